// ---- design/up_down_threshold_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
module up_down_threshold_counter #(
  parameter int N_REF = 16
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              reset,
  // Pulse and control pins, asynchronous
  input  wire logic                              count_in,
  input  wire logic                              dir_in,
  input  wire logic                              clear_in,
  // Power restore event, retentivity option, scan tick
  input  wire logic                              power_restore,
  input  wire logic                              retentive,
  input  wire logic                              scan_tick,
  // Threshold sources
  input  wire logic [updown_pkg::COUNT_W-1:0]    on_const,
  input  wire logic [updown_pkg::COUNT_W-1:0]    off_const,
  input  wire logic                              on_use_ref,
  input  wire logic                              off_use_ref,
  input  wire logic [updown_pkg::SEL_W-1:0]      on_ref_sel,
  input  wire logic [updown_pkg::SEL_W-1:0]      off_ref_sel,
  input  wire logic [N_REF*updown_pkg::REF_W-1:0] ref_values,
  // Results
  output logic [updown_pkg::COUNT_W-1:0]         count,
  output logic                                   switch_out
);
  localparam int CW = updown_pkg::COUNT_W;
  localparam int RW = updown_pkg::REF_W;

  logic [2:0] sync_cnt, sync_dir, sync_clr;
  logic       cnt_lvl, dir_lvl, clr_lvl, cnt_prev;
  logic       next_cnt_lvl, next_dir_lvl, next_clr_lvl, next_cnt_prev;
  logic [CW-1:0] next_count;
  logic          next_switch_out;
  logic [CW-1:0] on_thr, off_thr;
  logic          rise;

  // Three stages; a level change is taken once stages two and three agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_cnt <= 3'h0;
      sync_dir <= 3'h0;
      sync_clr <= 3'h0;
    end else begin
      sync_cnt <= {sync_cnt[1:0], count_in};
      sync_dir <= {sync_dir[1:0], dir_in};
      sync_clr <= {sync_clr[1:0], clear_in};
    end
  end

  // Referenced values are signed; clamp into 0..max
  function automatic logic [CW-1:0] clamp(input logic signed [RW-1:0] v);
    if (v < 0)
      clamp = '0;
    else if (v > $signed({{(RW-CW){1'b0}}, updown_pkg::COUNT_MAX}))
      clamp = updown_pkg::COUNT_MAX;
    else
      clamp = v[CW-1:0];
  endfunction

  always_comb begin
    on_thr  = on_const;
    off_thr = off_const;
    if (on_use_ref)
      on_thr = clamp(ref_values[on_ref_sel*RW +: RW]);
    if (off_use_ref)
      off_thr = clamp(ref_values[off_ref_sel*RW +: RW]);
  end

  // A pin that idles high through reset yields one false edge
  assign rise = cnt_lvl && !cnt_prev;

  always_comb begin
    next_cnt_lvl    = (sync_cnt[1] == sync_cnt[2]) ? sync_cnt[2] : cnt_lvl;
    next_dir_lvl    = (sync_dir[1] == sync_dir[2]) ? sync_dir[2] : dir_lvl;
    next_clr_lvl    = (sync_clr[1] == sync_clr[2]) ? sync_clr[2] : clr_lvl;
    next_cnt_prev   = cnt_lvl;
    next_count      = count;
    next_switch_out = switch_out;
    // Power loss outranks clear, clear outranks counting
    if (power_restore && !retentive) begin
      next_count      = updown_pkg::COUNT_RST;
      next_switch_out = 1'b0;
    end else if (clr_lvl) begin
      next_count      = updown_pkg::COUNT_RST;
      next_switch_out = 1'b0;
    end else begin
      if (rise) begin
        if (!dir_lvl && count != updown_pkg::COUNT_MAX)
          next_count = count + 1'b1;
        else if (dir_lvl && count != '0)
          next_count = count - 1'b1;
      end
      // Judged on the count held at the tick, so bursts can overshoot
      if (scan_tick) begin
        if (on_thr > off_thr) begin
          if (count >= on_thr)
            next_switch_out = 1'b1;
          else if (count < off_thr)
            next_switch_out = 1'b0;
        end else if (on_thr < off_thr)
          next_switch_out = (count > on_thr) && (count < off_thr);
        else
          // Equal thresholds leave an empty window
          next_switch_out = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_lvl    <= 1'b0;
      dir_lvl    <= 1'b0;
      clr_lvl    <= 1'b0;
      cnt_prev   <= 1'b0;
      count      <= updown_pkg::COUNT_RST;
      switch_out <= 1'b0;
    end else begin
      cnt_lvl    <= next_cnt_lvl;
      dir_lvl    <= next_dir_lvl;
      clr_lvl    <= next_clr_lvl;
      cnt_prev   <= next_cnt_prev;
      count      <= next_count;
      switch_out <= next_switch_out;
    end
  end

  // Checks use the filtered levels, so they see what the counter acts on
  clear_holds_a: assert property (@(posedge clk) disable iff (reset)
    clr_lvl && !power_restore |=> count == '0 && !switch_out)
    else $error("clear did not hold count and output low");

  clear_output_a: assert property (@(posedge clk) disable iff (reset)
    $past(clr_lvl) |-> !switch_out)
    else $error("output high while clear held");

  no_fall_count_a: assert property (@(posedge clk) disable iff (reset)
    !rise && !clr_lvl && !power_restore |=> $stable(count))
    else $error("count changed without rising edge");

  up_step_a: assert property (@(posedge clk) disable iff (reset)
    rise && !dir_lvl && !clr_lvl && !power_restore
      && count != updown_pkg::COUNT_MAX
      |=> count == $past(count) + 1'h1)
    else $error("up count step wrong");

  down_step_a: assert property (@(posedge clk) disable iff (reset)
    rise && dir_lvl && !clr_lvl && !power_restore && count != '0
      |=> count == $past(count) - 1'h1)
    else $error("down count step wrong");

  floor_hold_a: assert property (@(posedge clk) disable iff (reset)
    rise && dir_lvl && !clr_lvl && !power_restore && count == '0
      |=> count == '0)
    else $error("count wrapped below zero");

  count_range_a: assert property (@(posedge clk) disable iff (reset)
    count <= updown_pkg::COUNT_MAX)
    else $error("count out of range");

  power_clear_a: assert property (@(posedge clk) disable iff (reset)
    power_restore && !retentive |=> count == '0 && !switch_out)
    else $error("non-retentive power restore kept state");

  retain_keep_a: assert property (@(posedge clk) disable iff (reset)
    power_restore && retentive && !clr_lvl && !rise && !scan_tick
      |=> $stable(count) && $stable(switch_out))
    else $error("retentive power restore lost state");

  // Threshold checks judge the count held at the tick
  hyst_set_a: assert property (@(posedge clk) disable iff (reset)
    scan_tick && !clr_lvl && !power_restore && on_thr > off_thr
      && count >= on_thr |=> switch_out)
    else $error("output not set at upper threshold");

  hyst_clear_a: assert property (@(posedge clk) disable iff (reset)
    scan_tick && !clr_lvl && !power_restore && on_thr > off_thr
      && count < off_thr |=> !switch_out)
    else $error("output not cleared below lower threshold");

  hyst_hold_a: assert property (@(posedge clk) disable iff (reset)
    scan_tick && !clr_lvl && !power_restore && on_thr > off_thr
      && count < on_thr && count >= off_thr |=> $stable(switch_out))
    else $error("output moved inside hysteresis band");

  window_out_a: assert property (@(posedge clk) disable iff (reset)
    scan_tick && !clr_lvl && !power_restore && on_thr < off_thr
      |=> switch_out == ($past(count) > $past(on_thr)
                         && $past(count) < $past(off_thr)))
    else $error("window output wrong");

  equal_low_a: assert property (@(posedge clk) disable iff (reset)
    scan_tick && !clr_lvl && !power_restore && on_thr == off_thr
      |=> !switch_out)
    else $error("output high with equal thresholds");

  no_tick_hold_a: assert property (@(posedge clk) disable iff (reset)
    !scan_tick && !clr_lvl && !power_restore |=> $stable(switch_out))
    else $error("output changed outside scan tick");

  // Clamp checks watch the selected thresholds, not the raw references
  ref_clamp_a: assert property (@(posedge clk) disable iff (reset)
    on_use_ref |-> on_thr <= updown_pkg::COUNT_MAX)
    else $error("referenced threshold not clamped");

  off_clamp_a: assert property (@(posedge clk) disable iff (reset)
    off_use_ref |-> off_thr <= updown_pkg::COUNT_MAX)
    else $error("referenced lower threshold not clamped");

  ref_negative_a: assert property (@(posedge clk) disable iff (reset)
    on_use_ref && ref_values[on_ref_sel*RW + RW - 1] |-> on_thr == '0)
    else $error("negative reference not clamped to zero");

  // Main scenarios
  cov_up_c:     cover property (@(posedge clk) rise && !dir_lvl);
  cov_down_c:   cover property (@(posedge clk) rise && dir_lvl);
  cov_set_c:    cover property (@(posedge clk) $rose(switch_out));
  cov_clear_c:  cover property (@(posedge clk) $fell(switch_out) && clr_lvl);
  cov_ref_c:    cover property (@(posedge clk) off_use_ref && scan_tick);
endmodule
`default_nettype wire

// ---- design/updown_pkg.sv ----
package updown_pkg;
  localparam int          COUNT_W   = 20;
  localparam int          SEL_W     = 4;
  localparam int          REF_W     = 32;
  localparam logic [19:0] COUNT_MAX = 20'h0_F423F;
  localparam logic [19:0] COUNT_RST = 20'h0_0000;
endpackage

// ---- sim/pulse_source.sv ----
`timescale 1ns/100ps
`default_nettype none
module pulse_source (
  // Pulse line
  input  wire logic clk,
  output logic      pulse
);
  initial pulse = 1'h0;
  // High for 4 cycles, low for 5 between pulses, above the 2-cycle filter minimum
  task automatic send(input int n);
    repeat (n) begin
      @(posedge clk) pulse <= 1'h1;
      repeat (4) @(posedge clk);
      pulse <= 1'h0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/up_down_threshold_counter_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module up_down_threshold_counter_tb_top;
  logic         clk = 1'h0, reset = 1'h1, count_in, dir_in = 1'h0;
  logic         clear_in = 1'h0, power_restore = 1'h0, retentive = 1'h0;
  logic         scan_tick = 1'h0, on_use_ref = 1'h0, switch_out;
  logic         off_use_ref = 1'h0;
  logic [19:0]  on_const = 20'h0_0003, off_const = 20'h0_0001, count;
  logic [3:0]   on_ref_sel = 4'h2, off_ref_sel = 4'h1;
  logic [127:0] ref_values = '0;
  int           errors = 0, total_checks = 0, cycles = 0;
  always #2 clk = ~clk;
  pulse_source src (.clk(clk), .pulse(count_in));
  up_down_threshold_counter #(.N_REF(4)) uut (.clk(clk), .reset(reset),
    .count_in(count_in), .dir_in(dir_in), .clear_in(clear_in),
    .power_restore(power_restore), .retentive(retentive),
    .scan_tick(scan_tick), .on_const(on_const), .off_const(off_const),
    .on_use_ref(on_use_ref), .off_use_ref(off_use_ref),
    .on_ref_sel(on_ref_sel), .off_ref_sel(off_ref_sel),
    .ref_values(ref_values), .count(count),
    .switch_out(switch_out));
  task wrap_up;
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task chk(input string name, input logic [19:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task pulses(input logic d, input int n);
    @(posedge clk) dir_in <= d;
    src.send(n);
    repeat (8) @(posedge clk);
  endtask
  task scan(input logic exp);
    @(posedge clk) scan_tick <= 1'h1;
    @(posedge clk) scan_tick <= 1'h0;
    repeat (2) @(posedge clk);
    chk("switch_out", switch_out, exp);
  endtask
  task pwr(input logic r);
    @(posedge clk) retentive <= r;
    power_restore <= 1'h1;
    @(posedge clk) power_restore <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task t_count;
    pulses(1'h0, 3);
    chk("count up", count, 20'h0_0003);
    pulses(1'h1, 1);
    chk("count down", count, 20'h0_0002);
  endtask
  task t_hyst;
    scan(1'h0);
    pulses(1'h0, 1);
    chk("no tick", switch_out, 1'h0);
    scan(1'h1);
    pulses(1'h1, 2);
    scan(1'h1);
    pulses(1'h1, 1);
    scan(1'h0);
    pulses(1'h1, 1);
    chk("floor", count, 20'h0_0000);
  endtask
  task t_window;
    @(posedge clk) on_const <= 20'h0_0001;
    off_const <= 20'h0_0005;
    pulses(1'h0, 2);
    scan(1'h1);
    pulses(1'h1, 1);
    scan(1'h0);
  endtask
  task t_ref;
    // Negative clamps to 0, oversize to the maximum
    @(posedge clk) on_use_ref <= 1'h1;
    ref_values[64+:32] <= 32'hFFFF_FFFB;
    scan(1'h1);
    @(posedge clk) ref_values[64+:32] <= 32'h7FFF_FFFF;
    scan(1'h0);
    @(posedge clk) on_use_ref <= 1'h0;
    on_const <= 20'h0_0000;
    scan(1'h1);
    // Lower threshold by reference: negative clamps to 0, equal gives low
    @(posedge clk) off_use_ref <= 1'h1;
    ref_values[32+:32] <= 32'hFFFF_FFFF;
    scan(1'h0);
    @(posedge clk) ref_values[32+:32] <= 32'h0000_0002;
    scan(1'h1);
    @(posedge clk) off_use_ref <= 1'h0;
  endtask
  task t_clear;
    @(posedge clk) clear_in <= 1'h1;
    pulses(1'h0, 2);
    chk("clear count", count, 20'h0_0000);
    chk("clear out", switch_out, 1'h0);
    @(posedge clk) clear_in <= 1'h0;
    repeat (6) @(posedge clk);
    chk("after clear", count, 20'h0_0000);
  endtask
  task t_power;
    pulses(1'h0, 2);
    scan(1'h1);
    pwr(1'h1);
    chk("kept", count, 20'h0_0002);
    chk("kept out", switch_out, 1'h1);
    pwr(1'h0);
    chk("lost", count, 20'h0_0000);
    chk("lost out", switch_out, 1'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    t_count();
    t_hyst();
    t_window();
    t_ref();
    t_clear();
    t_power();
    wrap_up();
  end
endmodule
`default_nettype wire
